// ### cpu_exception_detect.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_exception_detect
    import exc_pkg::*;
#(
    parameter bit HAS_MMU           = 1'b0,
    parameter bit HAS_MPU           = 1'b0,
    parameter bit HAS_HW_DIV        = 1'b1,
    parameter bit ILLEGAL_CHECK_OPT = 1'b0,
    parameter bit ALIGN_DATA_OPT    = 1'b0,
    parameter bit ALIGN_DEST_OPT    = 1'b0,
    parameter bit DIV_CHECK_OPT     = 1'b1
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire instr_req_t req,
    input  wire mem_chk_t   mem,
    input  wire logic       user_mode,
    input  wire logic       exception_handling_flag,
    output var  logic       exc_take_r,
    output var  cause_t     exc_cause_r,
    output var  vector_t    exc_vector_r,
    output var  logic       set_handling_flag_r,
    output var  logic       clear_user_mode_r,
    output var  logic       write_exc_regs_r,
    output var  logic       tlb_miss_data_r
);

    //======================================================================
    // build-time gating
    //======================================================================
    // protection hardware forces the illegal and alignment checks on; the division check stays optional
    localparam bit PROT_ON    = HAS_MMU | HAS_MPU;
    localparam bit ILLEGAL_ON = PROT_ON | ILLEGAL_CHECK_OPT;
    localparam bit DATA_AL_ON = PROT_ON | ALIGN_DATA_OPT;
    localparam bit DEST_AL_ON = PROT_ON | ALIGN_DEST_OPT;
    localparam bit DIV_ON     = HAS_HW_DIV & DIV_CHECK_OPT;

    //======================================================================
    // priority pick
    //======================================================================
    // lowest set code wins, so the enum order is the priority order
    function automatic cause_t pick_cause(input logic [NUM_CAUSE-1:0] hits);
        cause_t r;
        r = C_NONE;
        for (int i = NUM_CAUSE - 1; i > 0; i--) begin
            if (hits[i]) begin
                r = cause_t'(i[4:0]);
            end
        end
        return r;
    endfunction : pick_cause

    function automatic logic is_fast_tlb(input cause_t c);
        return (c == C_FAST_TLB_I) || (c == C_FAST_TLB_D);
    endfunction : is_fast_tlb

    function automatic logic is_tlb_miss(input cause_t c);
        return is_fast_tlb(c) || (c == C_DOUBLE_TLB_I) || (c == C_DOUBLE_TLB_D);
    endfunction : is_tlb_miss

    //======================================================================
    // sub-checks
    //======================================================================
    logic data_access;
    logic data_mis;
    logic dest_mis;
    logic div_err;

    assign data_access = req.is_load | req.is_store | req.is_initda | req.is_flushda;

    align_check u_data_align (
        .enable     (DATA_AL_ON && req.valid && (req.is_load || req.is_store)),
        .size       (req.size),
        .addr_lo    (req.data_addr[1:0]),
        .misaligned (data_mis)
    );

    align_check u_dest_align (
        .enable     (DEST_AL_ON && req.valid && req.is_ctl_xfer),
        .size       (SZ_WORD),
        .addr_lo    (req.dest_addr[1:0]),
        .misaligned (dest_mis)
    );

    div_check u_div (
        .enable    (DIV_ON && req.valid && req.is_div),
        .is_signed (req.is_signed_div),
        .dividend  (req.dividend),
        .divisor   (req.divisor),
        .div_err   (div_err)
    );

    //======================================================================
    // condition collection
    //======================================================================
    logic [NUM_CAUSE-1:0] hits;
    logic                 imiss;
    logic                 dmiss;

    always_comb begin
        hits  = '0;
        imiss = HAS_MMU && req.valid && mem.itlb_miss;
        dmiss = HAS_MMU && req.valid && mem.dtlb_miss && data_access;
        hits[C_FAST_TLB_I]    = imiss && !exception_handling_flag;
        hits[C_DOUBLE_TLB_I]  = imiss && exception_handling_flag;
        hits[C_MPU_I]         = HAS_MPU && req.valid && mem.mpu_i_deny;
        hits[C_SUPER_IADDR]   = HAS_MMU && req.valid && user_mode
                                && mem.fetch_super;
        hits[C_TLB_PERM_X]    = HAS_MMU && req.valid && mem.itlb_deny;
        hits[C_ILLEGAL]       = ILLEGAL_ON && req.valid && req.is_undef
                                && !req.is_internal;
        hits[C_UNIMPL]        = req.valid && req.is_unimpl;
        hits[C_SUPER_INSTR]   = PROT_ON && req.valid && user_mode
                                && req.is_priv;
        hits[C_TRAP]          = req.valid && req.is_trap;
        hits[C_BREAK]         = req.valid && req.is_break;
        hits[C_MISALIGN_DEST] = dest_mis;
        hits[C_DIV_ERR]       = div_err;
        hits[C_MISALIGN_DATA] = data_mis;
        hits[C_FAST_TLB_D]    = dmiss && !exception_handling_flag;
        hits[C_DOUBLE_TLB_D]  = dmiss && exception_handling_flag;
        hits[C_SUPER_DADDR]   = HAS_MMU && req.valid && user_mode && mem.data_super
                                && (req.is_load || req.is_store || req.is_flushda);
        // cache management ignores page permissions
        hits[C_TLB_PERM_R]    = HAS_MMU && req.valid && mem.dtlb_deny && req.is_load
                                && !req.is_dcache_mgmt;
        hits[C_TLB_PERM_W]    = HAS_MMU && req.valid && mem.dtlb_deny && req.is_store
                                && !req.is_dcache_mgmt;
        hits[C_MPU_D]         = HAS_MPU && req.valid && mem.mpu_d_deny
                                && data_access;
    end

    //======================================================================
    // result registers
    //======================================================================
    cause_t  exc_cause_nxt;
    vector_t exc_vector_nxt;
    logic    exc_take_nxt;
    logic    set_handling_flag_nxt;
    logic    clear_user_mode_nxt;
    logic    write_exc_regs_nxt;
    logic    tlb_miss_data_nxt;

    always_comb begin
        exc_cause_nxt         = pick_cause(hits);
        exc_take_nxt          = (exc_cause_nxt != C_NONE);
        exc_vector_nxt        = VEC_NONE;
        if (is_fast_tlb(exc_cause_nxt)) begin
            exc_vector_nxt = VEC_FAST_TLB;
        end else if (exc_cause_nxt == C_BREAK) begin
            exc_vector_nxt = VEC_BREAK;
        end else if (exc_take_nxt) begin
            exc_vector_nxt = VEC_GENERAL;
        end
        set_handling_flag_nxt = is_fast_tlb(exc_cause_nxt);
        clear_user_mode_nxt   = PROT_ON && exc_take_nxt;
        // a nested fault must not overwrite the state of the first one
        write_exc_regs_nxt    = exc_take_nxt
                                && !(HAS_MMU && exception_handling_flag);
        tlb_miss_data_nxt     = tlb_miss_data_r;
        if (is_tlb_miss(exc_cause_nxt)) begin
            tlb_miss_data_nxt = (exc_cause_nxt == C_FAST_TLB_D)
                                || (exc_cause_nxt == C_DOUBLE_TLB_D);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            exc_take_r          <= 1'b0;
            exc_cause_r         <= C_NONE;
            exc_vector_r        <= VEC_NONE;
            set_handling_flag_r <= 1'b0;
            clear_user_mode_r   <= 1'b0;
            write_exc_regs_r    <= 1'b0;
            tlb_miss_data_r     <= 1'b0;
        end else begin
            exc_take_r          <= exc_take_nxt;
            exc_cause_r         <= exc_cause_nxt;
            exc_vector_r        <= exc_vector_nxt;
            set_handling_flag_r <= set_handling_flag_nxt;
            clear_user_mode_r   <= clear_user_mode_nxt;
            write_exc_regs_r    <= write_exc_regs_nxt;
            tlb_miss_data_r     <= tlb_miss_data_nxt;
        end
    end

    //======================================================================
    // checks
    //======================================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence trap_seen_s;
        req.valid && req.is_trap && hits[C_UNIMPL] == 1'b0;
    endsequence

    sequence tlb_miss_seen_s;
        HAS_MMU && req.valid && mem.itlb_miss;
    endsequence

    trap_to_general_a: assert property (
        trap_seen_s ##0 !(|hits[C_SUPER_INSTR:C_FAST_TLB_I])
        |=> exc_cause_r == C_TRAP && exc_vector_r == VEC_GENERAL)
        else $error("trap not reported on the general vector");

    break_vector_a: assert property (
        exc_take_r && exc_cause_r == C_BREAK |-> exc_vector_r == VEC_BREAK
        && $past(req.is_break))
        else $error("break cause without break instruction or vector");

    illegal_internal_a: assert property (
        req.valid && req.is_undef && req.is_internal |=> exc_cause_r != C_ILLEGAL)
        else $error("internal encoding flagged as illegal");

    fast_miss_flag_a: assert property (
        tlb_miss_seen_s ##0 !exception_handling_flag
        |=> exc_cause_r == C_FAST_TLB_I && set_handling_flag_r
        && exc_vector_r == VEC_FAST_TLB)
        else $error("fast miss did not set flag or vector");

    double_miss_keep_a: assert property (
        tlb_miss_seen_s ##0 exception_handling_flag
        |=> exc_cause_r == C_DOUBLE_TLB_I && !write_exc_regs_r
        && !set_handling_flag_r && exc_vector_r == VEC_GENERAL)
        else $error("double miss handled wrongly");

    miss_kind_hold_a: assert property (
        !is_tlb_miss(exc_cause_r) ##1 !is_tlb_miss(exc_cause_r)
        |-> $stable(tlb_miss_data_r))
        else $error("miss kind changed without a miss");

    mgmt_no_perm_a: assert property (
        req.valid && req.is_dcache_mgmt
        |=> exc_cause_r != C_TLB_PERM_R && exc_cause_r != C_TLB_PERM_W)
        else $error("cache management raised permission violation");

    user_clear_a: assert property (
        exc_take_r |-> clear_user_mode_r == PROT_ON)
        else $error("privilege bit not cleared on exception");

    regs_frozen_a: assert property (
        HAS_MMU && exception_handling_flag |=> !write_exc_regs_r)
        else $error("exception registers written while handling");

    one_cause_a: assert property (
        exc_take_r |-> |($past(hits) & (NUM_CAUSE'(1) << exc_cause_r))
        && ($past(hits) & ((NUM_CAUSE'(1) << exc_cause_r) - NUM_CAUSE'(1))
            & ~NUM_CAUSE'(1)) == '0)
        else $error("reported cause is not the highest priority hit");

    div_zero_a: assert property (
        DIV_ON && req.valid && req.is_div && req.divisor == DIV_ZERO
        && !(|hits[C_MISALIGN_DEST:C_FAST_TLB_I])
        |=> exc_cause_r == C_DIV_ERR)
        else $error("divide by zero not reported");

    // a lower code may win, so these only demand that something at least as urgent is taken
    sequence user_req_s;
        req.valid && user_mode;
    endsequence

    sequence data_ref_s;
        req.valid && (req.is_load || req.is_store || req.is_flushda);
    endsequence

    unimpl_taken_a: assert property (
        req.valid && req.is_unimpl
        |=> exc_take_r && exc_cause_r <= C_UNIMPL)
        else $error("unimplemented instruction not reported");

    illegal_forced_a: assert property (
        PROT_ON && req.valid && req.is_undef && !req.is_internal
        |=> exc_take_r && exc_cause_r <= C_ILLEGAL)
        else $error("undefined encoding not reported");

    super_instr_a: assert property (
        user_req_s ##0 (PROT_ON && req.is_priv)
        |=> exc_take_r && exc_cause_r <= C_SUPER_INSTR)
        else $error("privileged instruction allowed in user mode");

    super_iaddr_a: assert property (
        user_req_s ##0 (HAS_MMU && mem.fetch_super)
        |=> exc_take_r && exc_cause_r <= C_SUPER_IADDR)
        else $error("user fetch from supervisor range allowed");

    super_daddr_a: assert property (
        user_req_s ##0 data_ref_s ##0 (HAS_MMU && mem.data_super)
        |=> exc_take_r && exc_cause_r <= C_SUPER_DADDR)
        else $error("user access to supervisor data allowed");

    dest_mis_a: assert property (
        DEST_AL_ON && req.valid && req.is_ctl_xfer
        && (req.dest_addr[1:0] & WORD_ALIGN_MASK) != '0
        |=> exc_take_r && exc_cause_r <= C_MISALIGN_DEST)
        else $error("misaligned target not reported");

    byte_aligned_a: assert property (
        exc_cause_r == C_MISALIGN_DATA |-> $past(req.size) != SZ_BYTE)
        else $error("byte access flagged misaligned");

    miss_kind_a: assert property (
        is_tlb_miss(exc_cause_r)
        |-> tlb_miss_data_r == $past(mem.dtlb_miss && !mem.itlb_miss))
        else $error("miss kind flag disagrees with the missing side");

    mpu_region_a: assert property (
        HAS_MPU && req.valid && (mem.mpu_i_deny || (mem.mpu_d_deny && data_access))
        |=> exc_take_r)
        else $error("region violation not reported");

    fast_only_sets_a: assert property (
        set_handling_flag_r |-> exc_vector_r == VEC_FAST_TLB && !$past(exception_handling_flag))
        else $error("handling flag set outside a fast miss");

endmodule : cpu_exception_detect
`default_nettype wire

// ### exc_pkg.sv
//==========================================================================
// How it works
// - trap instruction raises software trap, vectored to general handler
// - break instruction is reported as break exception with break vector
// - valid but unimplemented instruction raises unimplemented exception
// - undefined opcode or extension raises illegal exception when checking is on
// - illegal checking forced on with MMU or MPU, build option otherwise
// - internally used undefined encodings never raise illegal exception
// - privileged instructions in user mode with MMU or MPU raise supervisor-only
// - user-mode fetch from supervisor-only range raises instruction address exception
// - user-mode load, store or flushda to supervisor data raises data exception
// - misaligned data checking forced on with MMU or MPU, optional otherwise
// - word needs four-byte, half-word two-byte alignment; bytes never misaligned
// - control transfer target not multiple of four raises misaligned destination
// - destination checking forced on with MMU or MPU, build option otherwise
// - divide by zero or most-negative by minus one raises division error
// - division error exists only with hardware divide
// - TLB miss with handling flag clear sets flag, fast TLB vector
// - TLB misses split into instruction and data kinds, kind flag readable
// - TLB miss with flag set is double miss, registers kept, general vector
// - TLB permission denial reports execute, read or write kind in cause
// - data cache management instructions never raise TLB permission violation
// - MPU no-match or denial raises region violation, instruction or data kind
// - taking exception with MMU or MPU clears user mode bit
// - with MMU, while handling flag set, exception registers are left unchanged
//==========================================================================
package exc_pkg;

    // priority: a lower code wins over a higher one
    typedef enum logic [4:0] {
        C_NONE          = 5'h00,
        C_FAST_TLB_I    = 5'h01,
        C_DOUBLE_TLB_I  = 5'h02,
        C_MPU_I         = 5'h03,
        C_SUPER_IADDR   = 5'h04,
        C_TLB_PERM_X    = 5'h05,
        C_ILLEGAL       = 5'h06,
        C_UNIMPL        = 5'h07,
        C_SUPER_INSTR   = 5'h08,
        C_TRAP          = 5'h09,
        C_BREAK         = 5'h0a,
        C_MISALIGN_DEST = 5'h0b,
        C_DIV_ERR       = 5'h0c,
        C_MISALIGN_DATA = 5'h0d,
        C_FAST_TLB_D    = 5'h0e,
        C_DOUBLE_TLB_D  = 5'h0f,
        C_SUPER_DADDR   = 5'h10,
        C_TLB_PERM_R    = 5'h11,
        C_TLB_PERM_W    = 5'h12,
        C_MPU_D         = 5'h13
    } cause_t;

    localparam int NUM_CAUSE = 20;

    typedef enum logic [1:0] {
        VEC_NONE     = 2'h0,
        VEC_GENERAL  = 2'h1,
        VEC_FAST_TLB = 2'h2,
        VEC_BREAK    = 2'h3
    } vector_t;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2
    } size_t;

    localparam logic [1:0]  WORD_ALIGN_MASK = 2'h3;
    localparam logic [1:0]  HALF_ALIGN_MASK = 2'h1;
    localparam logic [31:0] DIV_ZERO        = 32'h0000_0000;
    localparam logic [31:0] DIV_MOST_NEG    = 32'h8000_0000;
    localparam logic [31:0] DIV_MINUS_ONE   = 32'hffff_ffff;

    // one issued instruction from decode and execute
    typedef struct packed {
        logic        valid;
        logic        is_trap;
        logic        is_break;
        logic        is_unimpl;
        logic        is_undef;
        logic        is_internal;
        logic        is_priv;
        logic        is_load;
        logic        is_store;
        logic        is_initda;
        logic        is_flushda;
        logic        is_dcache_mgmt;
        logic        is_ctl_xfer;
        logic        is_div;
        logic        is_signed_div;
        size_t       size;
        logic [31:0] data_addr;
        logic [31:0] dest_addr;
        logic [31:0] dividend;
        logic [31:0] divisor;
    } instr_req_t;

    // lookup results from the translation or protection unit
    typedef struct packed {
        logic fetch_super;
        logic data_super;
        logic itlb_miss;
        logic dtlb_miss;
        logic itlb_deny;
        logic dtlb_deny;
        logic mpu_i_deny;
        logic mpu_d_deny;
    } mem_chk_t;

endpackage : exc_pkg

// ### align_check.sv
`timescale 1ns/10ps
`default_nettype none
module align_check
    import exc_pkg::*;
(
    input  wire logic        enable,
    input  wire size_t       size,
    input  wire logic [1:0]  addr_lo,
    output logic             misaligned
);
    //======================================================================
    // alignment test
    //======================================================================
    always_comb begin
        misaligned = 1'b0;
        if (enable) begin
            if (size == SZ_WORD) begin
                misaligned = |(addr_lo & WORD_ALIGN_MASK);
            end else if (size == SZ_HALF) begin
                misaligned = |(addr_lo & HALF_ALIGN_MASK);
            end
        end
    end
endmodule : align_check
`default_nettype wire

// ### div_check.sv
`timescale 1ns/10ps
`default_nettype none
module div_check
    import exc_pkg::*;
(
    input  wire logic        enable,
    input  wire logic        is_signed,
    input  wire logic [31:0] dividend,
    input  wire logic [31:0] divisor,
    output logic             div_err
);
    //======================================================================
    // unrepresentable quotient
    //======================================================================
    always_comb begin
        div_err = 1'b0;
        if (enable) begin
            if (divisor == DIV_ZERO) begin
                div_err = 1'b1;
            end else if (is_signed && dividend == DIV_MOST_NEG
                         && divisor == DIV_MINUS_ONE) begin
                div_err = 1'b1;
            end
        end
    end
endmodule : div_check
`default_nettype wire

// ### exc_pipe_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// pipeline side: owns the handling flag and privilege bit, acts on pulses
module exc_pipe_model (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic set_flag,
    input  wire logic clear_user,
    input  wire logic ld,
    input  wire logic ld_flag,
    input  wire logic ld_user,
    output logic      flag_r,
    output logic      user_r
);
    logic flag_nxt;
    logic user_nxt;

    always_comb begin
        flag_nxt = flag_r | set_flag;
        user_nxt = user_r & ~clear_user;
        // a bench load wins so scenarios start from a known privilege state
        if (ld) begin
            flag_nxt = ld_flag;
            user_nxt = ld_user;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
            user_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            user_r <= user_nxt;
        end
    end
endmodule : exc_pipe_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
    import exc_pkg::*;
;
    logic       core_clk;
    logic       rst_n;
    instr_req_t req_s;
    mem_chk_t   mem_s;
    logic       ld;
    logic       ld_flag;
    logic       ld_user;
    logic       user_mode;
    logic       hflag;
    logic       take;
    cause_t     cause;
    vector_t    vec;
    logic       set_fl;
    logic       clr_usr;
    logic       wr_regs;
    logic       miss_d;
    int         err_count;
    int         n_tests;
    int         cyc = 0;
    instr_req_t r;
    mem_chk_t   m;
    logic       fl;

    cpu_exception_detect #(.HAS_MMU(1'b1), .HAS_MPU(1'b1)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .req(req_s), .mem(mem_s),
        .user_mode(user_mode), .exception_handling_flag(hflag),
        .exc_take_r(take), .exc_cause_r(cause), .exc_vector_r(vec),
        .set_handling_flag_r(set_fl), .clear_user_mode_r(clr_usr),
        .write_exc_regs_r(wr_regs), .tlb_miss_data_r(miss_d));

    exc_pipe_model pipe_u (
        .core_clk(core_clk), .rst_n(rst_n), .set_flag(set_fl), .clear_user(clr_usr),
        .ld(ld), .ld_flag(ld_flag), .ld_user(ld_user), .flag_r(hflag), .user_r(user_mode));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ====================
    // shared tasks
    task automatic summarize;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            summarize();
        end
    end

    task automatic fail(input string s);
        err_count++;
        $display("CHECK FAILED %0t %s", $time, s);
    endtask : fail

    task automatic chk(input cause_t c);
        logic    t;
        vector_t v;
        t = (c != C_NONE);
        v = !t ? VEC_NONE : (c == C_BREAK) ? VEC_BREAK :
            (c == C_FAST_TLB_I || c == C_FAST_TLB_D) ? VEC_FAST_TLB : VEC_GENERAL;
        n_tests++;
        if (cause !== c || vec !== v || take !== t || clr_usr !== t || wr_regs !== (t & ~fl))
            fail($sformatf("cause %h vec %h, want %h %h", cause, vec, c, v));
    endtask : chk

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
            fail("status pulse or miss kind differs");
    endtask : chk_bit

    task automatic fresh;
        r = '0;
        r.valid = 1'b1;
        m = '0;
    endtask : fresh

    // one instruction is sampled once; the check lands after its answer edge
    task automatic run(input cause_t c);
        @(posedge core_clk);
        req_s <= r;
        mem_s <= m;
        @(posedge core_clk);
        req_s <= '0;
        mem_s <= '0;
        #1;
        chk(c);
    endtask : run

    task automatic setst(input logic f, input logic u);
        @(posedge core_clk);
        ld <= 1'b1;
        ld_flag <= f;
        ld_user <= u;
        @(posedge core_clk);
        ld <= 1'b0;
        fl = f;
    endtask : setst

    // ====================
    // scenarios
    task automatic t_basic;
        fresh(); r.is_trap = 1'b1; run(C_TRAP);
        r.valid = 1'b0; run(C_NONE);
        fresh(); r.is_break = 1'b1; run(C_BREAK);
        fresh(); r.is_unimpl = 1'b1; run(C_UNIMPL);
        fresh(); r.is_undef = 1'b1; run(C_ILLEGAL);
        r.is_internal = 1'b1; run(C_NONE);
    endtask : t_basic

    task automatic t_super;
        setst(1'b0, 1'b1);
        fresh(); r.is_priv = 1'b1; run(C_SUPER_INSTR);
        run(C_NONE);
        setst(1'b0, 1'b1);
        fresh(); m.fetch_super = 1'b1; run(C_SUPER_IADDR);
        setst(1'b0, 1'b1);
        fresh(); r.is_load = 1'b1; m.data_super = 1'b1; run(C_SUPER_DADDR);
        r.is_load = 1'b0; r.is_store = 1'b1; run(C_NONE);
    endtask : t_super

    task automatic t_align;
        logic bad;
        for (int s = 0; s < 3; s++) begin
            for (int a = 0; a < 4; a++) begin
                fresh();
                r.is_store = (s == 1);
                r.is_load = (s != 1);
                r.size = size_t'(s);
                r.data_addr = 32'h0000_1000 + 32'(a);
                bad = (s == 2 && a != 0) || (s == 1 && a[0]);
                run(bad ? C_MISALIGN_DATA : C_NONE);
            end
        end
        for (int a = 0; a < 4; a++) begin
            fresh();
            r.is_ctl_xfer = 1'b1;
            r.dest_addr = 32'h0000_2000 + 32'(a);
            run(a != 0 ? C_MISALIGN_DEST : C_NONE);
        end
    endtask : t_align

    task automatic div(input logic [31:0] a, input logic [31:0] b, input logic s,
                       input cause_t c);
        fresh();
        r.is_div = 1'b1;
        r.is_signed_div = s;
        r.dividend = a;
        r.divisor = b;
        run(c);
    endtask : div

    task automatic t_div;
        div(32'h0000_0007, 32'h0000_0000, 1'b0, C_DIV_ERR);
        div(32'h8000_0000, 32'hffff_ffff, 1'b1, C_DIV_ERR);
        div(32'h8000_0000, 32'hffff_ffff, 1'b0, C_NONE);
        div(32'h7fff_ffff, 32'hffff_ffff, 1'b1, C_NONE);
    endtask : t_div

    task automatic t_tlb;
        setst(1'b0, 1'b0);
        fresh(); m.itlb_miss = 1'b1; run(C_FAST_TLB_I);
        chk_bit(set_fl, 1'b1);
        chk_bit(miss_d, 1'b0);
        fl = 1'b1;
        fresh(); r.is_load = 1'b1; m.dtlb_miss = 1'b1; run(C_DOUBLE_TLB_D);
        chk_bit(set_fl, 1'b0);
        chk_bit(miss_d, 1'b1);
        fresh(); r.is_trap = 1'b1; run(C_TRAP);
        chk_bit(miss_d, 1'b1);
        setst(1'b0, 1'b0);
        fresh(); r.is_flushda = 1'b1; m.dtlb_miss = 1'b1; run(C_FAST_TLB_D);
        setst(1'b1, 1'b0);
        fresh(); m.itlb_miss = 1'b1; run(C_DOUBLE_TLB_I);
        chk_bit(miss_d, 1'b0);
    endtask : t_tlb

    task automatic t_perm;
        setst(1'b0, 1'b0);
        fresh(); m.itlb_deny = 1'b1; run(C_TLB_PERM_X);
        fresh(); r.is_load = 1'b1; m.dtlb_deny = 1'b1; run(C_TLB_PERM_R);
        r.is_load = 1'b0; r.is_store = 1'b1; run(C_TLB_PERM_W);
        fresh(); r.is_flushda = 1'b1; r.is_dcache_mgmt = 1'b1;
        m.dtlb_deny = 1'b1; run(C_NONE);
        fresh(); m.mpu_i_deny = 1'b1; run(C_MPU_I);
        fresh(); r.is_store = 1'b1; m.mpu_d_deny = 1'b1; run(C_MPU_D);
        fresh(); r.is_trap = 1'b1; r.is_break = 1'b1; m.itlb_deny = 1'b1;
        run(C_TLB_PERM_X);
        m.itlb_deny = 1'b0; run(C_TRAP);
        fresh(); r.is_load = 1'b1; r.size = SZ_WORD; r.data_addr = 32'h0000_0002;
        m.dtlb_miss = 1'b1; run(C_MISALIGN_DATA);
    endtask : t_perm

    initial begin
        rst_n = 1'b0;
        req_s = '0;
        mem_s = '0;
        ld = 1'b0;
        ld_flag = 1'b0;
        ld_user = 1'b0;
        err_count = 0;
        n_tests = 0;
        fl = 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk(C_NONE);
        t_basic();
        t_super();
        t_align();
        t_div();
        t_tlb();
        t_perm();
        summarize();
    end
endmodule : tb
`default_nettype wire
